// file: bench/psi_lamp_watch.sv
// Front-panel lamp observer: measures the length of each lit and dark stretch of one lamp.
// Assumes the lamp is a registered level that is stable at each rising core_clk edge.
`timescale 1ns/1ps
module psi_lamp_watch (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Lamp under watch
  input  wire logic        lamp,
  // Last completed stretches, in cycles
  output logic      [15:0] on_len,
  output logic      [15:0] off_len
);
  logic [15:0] run_q;
  logic        last_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_q   <= 16'h0000;
      last_q  <= 1'b0;
      on_len  <= 16'h0000;
      off_len <= 16'h0000;
    end else begin
      last_q <= lamp;
      if (lamp == last_q) begin
        run_q <= run_q + 16'h0001;
      end else begin
        run_q <= 16'h0001;
        if (last_q) begin
          on_len <= run_q;
        end else begin
          off_len <= run_q;
        end
      end
    end
  end
endmodule

// file: bench/psi_top_test.sv
// Self-checking bench of the front-panel status block.
// Assumes a shortened millisecond tick so blink cadences fit a short run.
`timescale 1ns/1ps
module test_psi_top;
  import psi_pkg::*;
  localparam int TK = 5;
  localparam int HALF = 500 * TK;
  localparam int COFF = 2500 * TK;
  logic        core_clk;
  logic        srst;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        power_int_ok;
  logic        ext_power_ok;
  logic        unit_healthy;
  logic        diag_pass;
  logic        started;
  logic        scanning;
  logic        config_valid;
  logic        link_traffic_ok;
  logic        link_error;
  psi_stop_s   stop_cause;
  logic        fatal_error;
  logic        fatal_kernel;
  logic [7:0]  crash_pattern;
  psi_lamps_s  lamps;
  logic [7:0]  input_lamps;
  logic        crash_kernel;
  logic [15:0] image_word;
  logic        image_word_vld;
  logic        image_commit;
  logic [15:0] run_on;
  logic [15:0] run_off;
  logic [15:0] link_on;
  logic [15:0] link_off;
  int          n_fail;
  int          checked;

  psi_top #(.LAMP_N(8), .TICK_CYC(TK)) psi_top_inst (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_int_ok(power_int_ok),
    .ext_power_ok(ext_power_ok), .unit_healthy(unit_healthy), .diag_pass(diag_pass),
    .started(started), .scanning(scanning), .config_valid(config_valid),
    .link_traffic_ok(link_traffic_ok), .link_error(link_error), .stop_cause(stop_cause),
    .fatal_error(fatal_error), .fatal_kernel(fatal_kernel), .crash_pattern(crash_pattern),
    .lamps(lamps), .input_lamps(input_lamps), .crash_kernel(crash_kernel),
    .image_word(image_word), .image_word_vld(image_word_vld), .image_commit(image_commit));
  psi_lamp_watch run_watch (.core_clk(core_clk), .srst(srst), .lamp(lamps.run),
    .on_len(run_on), .off_len(run_off));
  psi_lamp_watch link_watch (.core_clk(core_clk), .srst(srst), .lamp(lamps.link),
    .on_len(link_on), .off_len(link_off));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  // Let inputs land, then look at settled registered outputs
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    logic [15:0] m;
    n_fail = 0; checked = 0;
    srst = 1'b1; reg_addr = 16'h0000; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
    power_int_ok = 1'b0; ext_power_ok = 1'b0; unit_healthy = 1'b0; diag_pass = 1'b0;
    started = 1'b0; scanning = 1'b0; config_valid = 1'b1; link_traffic_ok = 1'b0;
    link_error = 1'b0; stop_cause = psi_stop_s'(16'h0000); fatal_error = 1'b0;
    fatal_kernel = 1'b0; crash_pattern = 8'hA5;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk("exec rev", EXEC_REV_ADDR, 16'h0101);
    settle(1);
    chk("rdata idle", 16'h0000, reg_rdata);
    wr(EXEC_REV_ADDR, 16'h1234);
    rd_chk("exec rev ro", EXEC_REV_ADDR, 16'h0101);
    rd_chk("unmapped", 16'h4000, 16'h0000);
    rd_chk("stop rst", STOP_WORD_ADDR, 16'h0000);
    // Supply lamp over the four power combinations
    for (int i = 0; i < 4; i++) begin
      power_int_ok <= i[0];
      ext_power_ok <= i[1];
      settle(3);
      chk("supply", {15'h0000, i == 3}, {15'h0000, lamps.supply});
    end
    chk("ready early", 16'h0000, {15'h0000, lamps.ready});
    diag_pass <= 1'b1;
    unit_healthy <= 1'b1;
    settle(4);
    chk("ready", 16'h0001, {15'h0000, lamps.ready});
    unit_healthy <= 1'b0;
    settle(4);
    chk("ready lost", 16'h0000, {15'h0000, lamps.ready});
    unit_healthy <= 1'b1;
    // Every stop position alone, then all at once
    for (int i = 0; i < 16; i++) begin
      m = 16'h0001 << i;
      @(posedge core_clk);
      stop_cause <= psi_stop_s'(m);
      @(posedge core_clk);
      stop_cause <= psi_stop_s'(16'h0000);
      rd_chk("stop", STOP_WORD_ADDR, m & STOP_DEFINED);
      wr(STOP_WORD_ADDR, 16'hFFFF);
      rd_chk("stop clr", STOP_WORD_ADDR, 16'h0000);
    end
    @(posedge core_clk);
    stop_cause <= psi_stop_s'(16'hFFFF);
    @(posedge core_clk);
    stop_cause <= psi_stop_s'(16'h0000);
    rd_chk("stop or", STOP_WORD_ADDR, 16'hFEFF);
    wr(STOP_WORD_ADDR, 16'hFFFF);
    // Run lamp steady, then flashing without a valid setup
    started <= 1'b1;
    scanning <= 1'b1;
    settle(HALF + 100);
    chk("run steady", 16'h0001, {15'h0000, lamps.run});
    chk("run no blink", 16'h0000, run_on);
    started <= 1'b0;
    scanning <= 1'b0;
    config_valid <= 1'b0;
    settle(4 * HALF);
    chk("run flash on", HALF[15:0], run_on);
    chk("run flash off", HALF[15:0], run_off);
    rd_chk("no setup", STOP_WORD_ADDR, 16'h2000);
    config_valid <= 1'b1;
    settle(2);
    wr(STOP_WORD_ADDR, 16'hFFFF);
    rd_chk("setup clr", STOP_WORD_ADDR, 16'h0000);
    // Link lamp steady, then flashing on errors
    link_traffic_ok <= 1'b1;
    settle(HALF + 100);
    chk("link steady", 16'h0001, {15'h0000, lamps.link});
    chk("link no blink", 16'h0000, link_on);
    link_error <= 1'b1;
    settle(4 * HALF);
    chk("link flash on", HALF[15:0], link_on);
    chk("link flash off", HALF[15:0], link_off);
    link_error <= 1'b0;
    // Executive image supplied word by word, then committed
    wr(IMAGE_DATA_ADDR, 16'hC3A5);
    #1;
    chk("image word", 16'hC3A5, image_word);
    chk("image vld", 16'h0001, {15'h0000, image_word_vld});
    wr(IMAGE_REV_ADDR, 16'h0102);
    rd_chk("rev stage", IMAGE_REV_ADDR, 16'h0102);
    wr(IMAGE_CTRL_ADDR, 16'h0001);
    #1;
    chk("commit", 16'h0001, {15'h0000, image_commit});
    rd_chk("new rev", EXEC_REV_ADDR, 16'h0102);
    // Kernel crash: pattern, steady ready, run in step with inputs
    @(posedge core_clk);
    fatal_kernel <= 1'b1;
    fatal_error  <= 1'b1;
    @(posedge core_clk);
    fatal_error <= 1'b0;
    settle(2);
    chk("crash lamps", 16'h00A5, {8'h00, input_lamps});
    chk("crash kernel", 16'h0001, {15'h0000, crash_kernel});
    chk("crash run", 16'h0001, {15'h0000, lamps.run});
    rd_chk("status", STATUS_ADDR, 16'h000F);
    settle(2 * (HALF + COFF) + 100);
    chk("crash ready", 16'h0001, {15'h0000, lamps.ready});
    chk("crash on", HALF[15:0], run_on);
    chk("crash off", COFF[15:0], run_off);
    // Power loss leaves the crash; an application crash follows
    power_int_ok <= 1'b0;
    settle(4);
    chk("crash left", 16'h0000, {8'h00, input_lamps});
    power_int_ok <= 1'b1;
    settle(4);
    fatal_kernel <= 1'b0;
    fatal_error  <= 1'b1;
    crash_pattern <= 8'h3C;
    @(posedge core_clk);
    fatal_error <= 1'b0;
    settle(3);
    chk("app crash", 16'h0000, {15'h0000, crash_kernel});
    chk("app lamps", 16'h003C, {8'h00, input_lamps});
    print_verdict();
  end
endmodule

// file: rtl/psi_blink.sv
// Lamp cadence generator: a millisecond enable and two blink phases.
// Assumes restart is a one-cycle pulse from the top when a crash starts.
`timescale 1ns/1ps
module psi_blink
  import psi_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Crash cadence restart
  input  wire logic restart,
  // Phases
  output logic      flash_on,
  output logic      crash_on
);
  localparam logic [11:0] CRASH_PERIOD = CRASH_ON_MS + CRASH_OFF_MS;

  logic [15:0] div_q;
  logic [11:0] flash_ms_q;
  logic [11:0] crash_ms_q;
  logic        flash_q;
  logic        crash_q;
  wire         tick      = (div_q == 16'(TICK_CYC - 1));
  wire         flash_end = (flash_ms_q == FLASH_HALF_MS - 12'h001);
  wire         crash_end = (crash_ms_q == CRASH_PERIOD - 12'h001);

  always_ff @(posedge core_clk) begin
    if (srst || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flash_ms_q <= 12'h000;
      flash_q    <= 1'b0;
    end else if (tick) begin
      flash_ms_q <= flash_end ? 12'h000 : flash_ms_q + 12'h001;
      flash_q    <= flash_end ? ~flash_q : flash_q;
    end
  end

  // On for the first CRASH_ON_MS of each period, then dark
  always_ff @(posedge core_clk) begin
    if (srst || restart) begin
      crash_ms_q <= 12'h000;
      crash_q    <= 1'b1;
    end else if (tick) begin
      crash_ms_q <= crash_end ? 12'h000 : crash_ms_q + 12'h001;
      crash_q    <= crash_end || (crash_ms_q < CRASH_ON_MS - 12'h001);
    end
  end

  assign flash_on = flash_q;
  assign crash_on = crash_q;
endmodule

// file: rtl/psi_pkg.sv
// Constants, register map and carrier types of the front-panel status block.
// Assumes a single 50 MHz core clock; all times are derived from it here.
package psi_pkg;

  // Register map (byte addresses on the 16-bit register port)
  localparam logic [15:0] EXEC_REV_ADDR  = 16'h4020;
  localparam logic [15:0] STOP_WORD_ADDR = 16'h4024;
  localparam logic [15:0] STATUS_ADDR    = 16'h4028;
  localparam logic [15:0] IMAGE_DATA_ADDR = 16'h402C;
  localparam logic [15:0] IMAGE_REV_ADDR = 16'h4030;
  localparam logic [15:0] IMAGE_CTRL_ADDR = 16'h4034;

  // Reset values
  localparam logic [15:0] EXEC_REV_RST   = 16'h0101;
  localparam logic [15:0] STOP_WORD_RST  = 16'h0000;
  // Only the documented stop positions may ever be set
  localparam logic [15:0] STOP_DEFINED   = 16'hFEFF;

  // Field positions
  localparam int STOP_HALT_BIT    = 15;
  localparam int STOP_NOSETUP_BIT = 13;
  localparam int STAT_CRASH_BIT   = 0;
  localparam int STAT_KERNEL_BIT  = 1;
  localparam int STAT_READY_BIT   = 2;
  localparam int STAT_RUN_BIT     = 3;
  localparam int CTRL_COMMIT_BIT  = 0;

  // Timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          TICK_NS       = 1000000;
  localparam int          TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] FLASH_HALF_MS = 12'h1F4;
  localparam logic [11:0] CRASH_ON_MS   = 12'h1F4;
  localparam logic [11:0] CRASH_OFF_MS  = 12'h9C4;

  // Stop causes, bit 15 down to bit 0
  typedef struct packed {
    logic controller_halted_flag;
    logic io_map_fault;
    logic no_valid_setup_flag;
    logic port_intrusion_fault;
    logic segment_schedule_fault;
    logic network_start_fault;
    logic powerdown_sum_fault;
    logic unused_cause;
    logic scan_overrun_fault;
    logic calendar_clock_fault;
    logic coil_table_fault;
    logic expansion_link_fault;
    logic illegal_element_fault;
    logic program_sum_fault;
    logic discrete_inhibit_fault;
    logic setup_invalid_fault;
  } psi_stop_s;

  typedef struct packed {
    logic supply;
    logic ready;
    logic run;
    logic link;
  } psi_lamps_s;

  typedef enum logic [2:0] {
    MODE_BOOT  = 3'b001,
    MODE_UP    = 3'b010,
    MODE_CRASH = 3'b100
  } psi_mode_e;

endpackage

// file: rtl/psi_top.sv
// Front-panel status block: indicator lamps, stop word, crash display,
// executive revision and executive image port.
// Assumes monitor inputs are synchronous to core_clk and the register
// master never issues read and write strobes together.
//
// What this block does
// - Supply lamp lit exactly while internal and external power are healthy.
// - Ready lamp lit after diagnostics pass, kept while powered and healthy.
// - Run lamp steady while started and scanning ladder logic, outside a crash.
// - Run lamp flashes when powered but no valid configuration exists, unless steady or in a crash.
// - Link lamp steady during valid expansion traffic, same on both units.
// - Link lamp flashes while expansion link errors are detected.
// - Unexpected stop recorded in a readable 16-bit stop word.
// - Bits for stopped state, missing configuration and bad configuration.
// - Bits for segment scheduling, network start and illegal element faults.
// - Bits for power-down checksum, program checksum and coil table faults.
// - Watchdog bit set when scan overruns the watchdog.
// - Bits for calendar clock failure and expansion link failure.
// - Bits for I/O map, port intrusion and discrete inhibit faults.
// - Fatal error flashes a crash pattern on the input lamps.
// - Crash category kept: kernel mode or application.
// - Executive revision word readable at 4020 hex, reset value 0101.
// - Executive image rewritable through the register port, no hardware change.
`timescale 1ns/1ps
module psi_top
  import psi_pkg::*;
#(
  parameter int LAMP_N   = 8,
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Register port
  input  wire logic [15:0]       reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  // Health and scan monitors
  input  wire logic              power_int_ok,
  input  wire logic              ext_power_ok,
  input  wire logic              unit_healthy,
  input  wire logic              diag_pass,
  input  wire logic              started,
  input  wire logic              scanning,
  input  wire logic              config_valid,
  // Expansion link monitor
  input  wire logic              link_traffic_ok,
  input  wire logic              link_error,
  // Stop causes and fatal errors
  input  wire psi_stop_s         stop_cause,
  input  wire logic              fatal_error,
  input  wire logic              fatal_kernel,
  input  wire logic [LAMP_N-1:0] crash_pattern,
  // Lamps
  output psi_lamps_s             lamps,
  output logic      [LAMP_N-1:0] input_lamps,
  output logic                   crash_kernel,
  // Executive image stream
  output logic      [15:0]       image_word,
  output logic                   image_word_vld,
  output logic                   image_commit
);

  // Register decode
  wire sel_rev    = (reg_addr == EXEC_REV_ADDR);
  wire sel_stop   = (reg_addr == STOP_WORD_ADDR);
  wire sel_stat   = (reg_addr == STATUS_ADDR);
  wire sel_idata  = (reg_addr == IMAGE_DATA_ADDR);
  wire sel_irev   = (reg_addr == IMAGE_REV_ADDR);
  wire sel_ictrl  = (reg_addr == IMAGE_CTRL_ADDR);
  wire wr_stop    = reg_wr && sel_stop;
  wire wr_idata   = reg_wr && sel_idata;
  wire wr_irev    = reg_wr && sel_irev;
  wire wr_commit  = reg_wr && sel_ictrl && reg_wdata[CTRL_COMMIT_BIT];

  // Health terms
  wire power_ok   = power_int_ok && ext_power_ok;
  wire healthy    = power_ok && unit_healthy;

  // State
  psi_mode_e         mode_q;
  psi_mode_e         mode_d;
  psi_lamps_s        lamps_q;
  psi_lamps_s        lamps_d;
  logic [15:0]       stop_q;
  logic [15:0]       stop_d;
  logic [15:0]       exec_rev_q;
  logic [15:0]       rev_stage_q;
  logic [15:0]       rdata_q;
  logic [15:0]       rdata_d;
  logic [LAMP_N-1:0] crash_pat_q;
  logic [LAMP_N-1:0] in_lamps_q;
  logic              kernel_q;
  logic [15:0]       image_word_q;
  logic              image_vld_q;
  logic              image_commit_q;
  logic              flash_on;
  logic              crash_on;

  wire in_crash    = (mode_q == MODE_CRASH);
  wire crash_entry = (mode_d == MODE_CRASH) && !in_crash;

  psi_blink #(
    .TICK_CYC (TICK_CYC)
  ) u_blink (
    .core_clk (core_clk),
    .srst     (srst),
    .restart  (crash_entry),
    .flash_on (flash_on),
    .crash_on (crash_on)
  );

  // Operating mode
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_BOOT: begin
        if (fatal_error && power_ok) begin
          mode_d = MODE_CRASH;
        end else if (diag_pass && healthy) begin
          mode_d = MODE_UP;
        end
      end
      MODE_UP: begin
        if (fatal_error && power_ok) begin
          mode_d = MODE_CRASH;
        end else if (!healthy) begin
          mode_d = MODE_BOOT;
        end
      end
      MODE_CRASH: begin
        if (!power_ok) begin
          mode_d = MODE_BOOT;
        end
      end
      default: begin
        mode_d = MODE_BOOT;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_q <= MODE_BOOT;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Lamp selection
  wire run_steady = started && scanning;
  wire run_flash  = power_ok && !config_valid;
  wire run_lamp   = in_crash   ? crash_on :
                    run_steady ? 1'b1 :
                    run_flash  ? flash_on : 1'b0;
  wire link_lamp  = link_error      ? flash_on :
                    link_traffic_ok ? 1'b1 : 1'b0;

  always_comb begin
    lamps_d.supply = power_ok;
    lamps_d.ready  = (mode_q == MODE_UP) || in_crash;
    lamps_d.run    = run_lamp;
    lamps_d.link   = link_lamp;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lamps_q <= '0;
    end else begin
      lamps_q <= lamps_d;
    end
  end

  // Crash capture and display
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crash_pat_q <= '0;
      kernel_q    <= 1'b0;
    end else if (crash_entry) begin
      crash_pat_q <= crash_pattern;
      kernel_q    <= fatal_kernel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      in_lamps_q <= '0;
    end else begin
      in_lamps_q <= (in_crash && crash_on) ? crash_pat_q : '0;
    end
  end

  // Stop word: sticky causes, write one to clear, a new cause wins
  wire [15:0] cause_bits = stop_cause
                         | (16'(run_flash) << STOP_NOSETUP_BIT);
  wire [15:0] clr_mask   = wr_stop ? reg_wdata : 16'h0000;

  assign stop_d = ((stop_q & ~clr_mask) | cause_bits) & STOP_DEFINED;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stop_q <= STOP_WORD_RST;
    end else begin
      stop_q <= stop_d;
    end
  end

  // Executive revision and image stream
  always_ff @(posedge core_clk) begin
    if (srst) begin
      exec_rev_q  <= EXEC_REV_RST;
      rev_stage_q <= EXEC_REV_RST;
    end else begin
      if (wr_irev) begin
        rev_stage_q <= reg_wdata;
      end
      if (wr_commit) begin
        exec_rev_q <= rev_stage_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      image_word_q   <= 16'h0000;
      image_vld_q    <= 1'b0;
      image_commit_q <= 1'b0;
    end else begin
      image_word_q   <= wr_idata ? reg_wdata : image_word_q;
      image_vld_q    <= wr_idata;
      image_commit_q <= wr_commit;
    end
  end

  // Read data, valid in the cycle after the strobe; unmapped reads zero
  wire [15:0] status_word = (16'(in_crash) << STAT_CRASH_BIT)
                          | (16'(kernel_q) << STAT_KERNEL_BIT)
                          | (16'(lamps_q.ready) << STAT_READY_BIT)
                          | (16'(lamps_q.run) << STAT_RUN_BIT);

  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      if (sel_rev) begin
        rdata_d = exec_rev_q;
      end else if (sel_stop) begin
        rdata_d = stop_q;
      end else if (sel_stat) begin
        rdata_d = status_word;
      end else if (sel_irev) begin
        rdata_d = rev_stage_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata      = rdata_q;
  assign lamps          = lamps_q;
  assign input_lamps    = in_lamps_q;
  assign crash_kernel   = kernel_q;
  assign image_word     = image_word_q;
  assign image_word_vld = image_vld_q;
  assign image_commit   = image_commit_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_boot_ok;
    (mode_q == MODE_BOOT) && diag_pass && healthy && !fatal_error;
  endsequence

  sequence s_crash_held;
    in_crash [*2];
  endsequence

  supply_lamp_a: assert property (##1 lamps_q.supply == $past(power_ok))
    else $error("supply lamp does not follow power");

  ready_on_a: assert property (s_boot_ok |=> (mode_q == MODE_UP) ##1 lamps_q.ready)
    else $error("ready lamp did not come on after diagnostics");

  ready_drop_a: assert property ((mode_q == MODE_UP) && !healthy && !fatal_error
                                 |=> ##1 !lamps_q.ready)
    else $error("ready lamp held after health loss");

  run_steady_a: assert property (!in_crash && run_steady |=> lamps_q.run)
    else $error("run lamp not steady while scanning");

  run_flash_a: assert property (!in_crash && !run_steady && run_flash
                                |=> lamps_q.run == $past(flash_on))
    else $error("run lamp not flashing without configuration");

  link_steady_a: assert property (link_traffic_ok && !link_error |=> lamps_q.link)
    else $error("link lamp not steady on valid traffic");

  link_flash_a: assert property (link_error |=> lamps_q.link == $past(flash_on))
    else $error("link lamp not flashing on link error");

  stop_set_a: assert property (##1 ((stop_q & $past(stop_cause) & STOP_DEFINED)
                               == ($past(stop_cause) & STOP_DEFINED)))
    else $error("stop cause lost, set must win over clear");

  stop_halt_a: assert property (stop_cause.controller_halted_flag
                                |=> stop_q[STOP_HALT_BIT] [*1])
    else $error("halted bit not recorded");

  stop_gap_a: assert property (stop_q[8] == 1'b0)
    else $error("undefined stop position set");

  crash_lamps_a: assert property (s_crash_held |-> lamps_q.ready
                                  && (lamps_q.run == $past(crash_on)))
    else $error("ready or run lamp wrong during crash");

  crash_inputs_a: assert property (s_crash_held |=> in_lamps_q ==
                                   ($past(crash_on) ? crash_pat_q : '0))
    else $error("crash pattern not flashed on input lamps");

  crash_kind_a: assert property (crash_entry |=> kernel_q == $past(fatal_kernel))
    else $error("crash category not captured");

  rev_read_a: assert property (reg_rd && sel_rev |=> rdata_q == $past(exec_rev_q))
    else $error("revision readback wrong");

  image_rev_a: assert property (wr_commit |=> exec_rev_q == $past(rev_stage_q)
                                && image_commit)
    else $error("executive image commit not applied");

endmodule
